// File: adc_serial_result_port.sv
// adc_serial_result_port: device end; result word, chain shift, ready and over-range
// assumes: shift clock arrives asynchronously and is sampled by clk_i
`timescale 1ns/1ps

// How it works
// (R1) shift chain and output at shift clock rate
// (R2) shift clock sampled as independent domain
// (R3) host idles shift clock during sample collection
// (R4) host syncs shift clock if shifting then
// (R5) host gates shift clock to transfers only
// (R6) output register passes chain input through
// (R7) word is 21-bit twos or 20-bit binary
// (R8) most significant bit goes first
// (R9) output tri-stated while transmit disabled
// (R10) ready set at completion until transmit
// (R11) over-range flags are open-collector
// (R12) flag set when feedback or filter overflow while converting
// (R13) flags clear one clock after ready
// (R14) host captures flags on ready rise
// (R15) host holds transmit until chain drained
// (R16) final start begins m-sample collection
// (R17) format comes from configuration field
// (R18) output changes on falling, sampled rising
module adc_serial_result_port
    import adc_link_pkg::*;
(
    input  wire logic                 clk_i,          // system clock
    input  wire logic                 resetn_i,       // async reset, active low
    adc_link_if.device                link,           // pins to host
    input  wire logic                 fmt_sel_i,      // output format field
    input  wire logic [RES_W-1:0]     conv_data_i,    // filter result word
    input  wire logic                 dac_ovr_pos_i,  // feedback converter over full scale
    input  wire logic                 dac_ovr_neg_i,  // feedback converter under full scale
    input  wire logic                 flt_ovr_pos_i,  // filter over full scale
    input  wire logic                 flt_ovr_neg_i,  // filter under full scale
    output logic                      converting_o    // sample collection busy
);
    import adc_link_pkg::*;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_CONV = 3'b010,
        ST_DONE = 3'b100
    } conv_state_e;

    conv_state_e             state_r;
    logic [CONV_CNT_W-1:0]   conv_cnt_r;
    logic [2:0]              sclk_sync_r, xen_sync_r, fss_sync_r, din_sync_r;
    logic                    sclk_lvl_r, xen_lvl_r, fss_lvl_r;
    logic                    sclk_rise, sclk_fall, fss_rise;
    logic [RES_W-1:0]        shreg_r;
    logic                    din_cap_r;
    logic                    ready_r, ovr_pos_r, ovr_neg_r, clr_pend_r, sdata_r;
    logic                    done;

    // three-stage sampling; change counts when stages 2 and 3 agree
    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            sclk_sync_r <= 3'b000;
            xen_sync_r  <= 3'b000;
            fss_sync_r  <= 3'b000;
            din_sync_r  <= 3'b000;
        end
        else
        begin
            sclk_sync_r <= {sclk_sync_r[1:0], link.sclk};  // see (R2)
            xen_sync_r  <= {xen_sync_r[1:0], link.xmit_en};
            fss_sync_r  <= {fss_sync_r[1:0], link.final_sample_start};
            din_sync_r  <= {din_sync_r[1:0], link.chain_in};
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            sclk_lvl_r <= 1'b0;
            xen_lvl_r  <= 1'b0;
            fss_lvl_r  <= 1'b0;
        end
        else
        begin
            if (sclk_sync_r[1] == sclk_sync_r[2])
                sclk_lvl_r <= sclk_sync_r[2];
            if (xen_sync_r[1] == xen_sync_r[2])
                xen_lvl_r <= xen_sync_r[2];
            if (fss_sync_r[1] == fss_sync_r[2])
                fss_lvl_r <= fss_sync_r[2];
        end
    end

    assign sclk_rise = (sclk_sync_r[1] == sclk_sync_r[2]) && sclk_sync_r[2] && !sclk_lvl_r;
    assign sclk_fall = (sclk_sync_r[1] == sclk_sync_r[2]) && !sclk_sync_r[2] && sclk_lvl_r;
    assign fss_rise  = (fss_sync_r[1] == fss_sync_r[2]) && fss_sync_r[2] && !fss_lvl_r;

    // conversion sequencing: final sample collection then result
    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            state_r    <= ST_IDLE;
            conv_cnt_r <= '0;
        end
        else
        begin
            case (state_r)
                ST_IDLE:
                begin
                    if (fss_rise)
                    begin
                        state_r    <= ST_CONV;  // see (R16)
                        conv_cnt_r <= CONV_CNT_W'(FINAL_SAMPLES + CONV_CYC - 1);
                    end
                end
                ST_CONV:
                begin
                    if (conv_cnt_r == '0)
                        state_r <= ST_DONE;
                    else
                        conv_cnt_r <= conv_cnt_r - 1'b1;
                end
                ST_DONE:
                    state_r <= ST_IDLE;
                default:
                    state_r <= ST_IDLE;
            endcase
        end
    end

    assign done         = (state_r == ST_DONE);
    assign converting_o = (state_r == ST_CONV);

    // shift register: data captured on rising, shifted out on falling
    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            shreg_r   <= '0;
            din_cap_r <= 1'b0;
            sdata_r   <= 1'b0;
        end
        else if (done)
        begin
            if (fmt_sel_i == FMT_BIN)  // see (R7) (R17)
                shreg_r <= {conv_data_i[RES_W_BIN-1:0], 1'b0};
            else
                shreg_r <= conv_data_i;
            sdata_r <= (fmt_sel_i == FMT_BIN) ? conv_data_i[RES_W_BIN-1] : conv_data_i[RES_W-1];
        end
        else if (xen_lvl_r)
        begin
            if (sclk_rise)
                din_cap_r <= din_sync_r[2];  // see (R1)
            if (sclk_fall)
            begin
                shreg_r <= {shreg_r[RES_W-2:0], din_cap_r};  // see (R6) (R8)
                sdata_r <= shreg_r[RES_W-2];                   // see (R18)
            end
        end
    end

    assign link.sdata    = sdata_r;
    assign link.sdata_oe = xen_lvl_r;  // see (R9)

    // ready and over-range flags
    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            ready_r    <= 1'b0;
            ovr_pos_r  <= 1'b0;
            ovr_neg_r  <= 1'b0;
            clr_pend_r <= 1'b0;
        end
        else
        begin
            if (done)
                ready_r <= 1'b1;  // see (R10)
            else if (xen_lvl_r)
                ready_r <= 1'b0;
            clr_pend_r <= done;
            if (converting_o && (dac_ovr_pos_i || flt_ovr_pos_i))
                ovr_pos_r <= 1'b1;  // see (R12)
            else if (clr_pend_r)
                ovr_pos_r <= 1'b0;  // see (R13)
            if (converting_o && (dac_ovr_neg_i || flt_ovr_neg_i))
                ovr_neg_r <= 1'b1;
            else if (clr_pend_r)
                ovr_neg_r <= 1'b0;
        end
    end

    assign link.ready      = ready_r;
    assign link.ovr_pos_o  = 1'b0;  // see (R11)
    assign link.ovr_pos_oe = ovr_pos_r;
    assign link.ovr_neg_o  = 1'b0;
    assign link.ovr_neg_oe = ovr_neg_r;
endmodule : adc_serial_result_port

// File: adc_link_pkg.sv
// adc_link_pkg: shared constants for the serial result port and its host reader
// assumes: one 10 MHz system clock; the shift clock comes from the host end
package adc_link_pkg;
    localparam int unsigned RES_W          = 21;     // two's complement word width
    localparam int unsigned RES_W_BIN      = 20;     // straight binary word width
    localparam int unsigned CNT_W          = 8;      // bit counter width on host side
    localparam int unsigned SCLK_PERIOD_NS = 800;    // shift clock period
    localparam int unsigned CLK_PERIOD_NS  = 100;    // system clock period
    localparam int unsigned SCLK_HALF_CYC  = SCLK_PERIOD_NS / (2 * CLK_PERIOD_NS);
    localparam int unsigned FINAL_SAMPLES  = 16;     // m final sample points
    localparam int unsigned CONV_CYC       = 64;     // cycles after the final samples to result
    localparam int unsigned CONV_CNT_W     = 8;
    localparam int unsigned FSS_HOLD_CYC   = 4;      // start level length; a one-clock pulse never passes the pin filter
    localparam logic        FMT_TWOS       = 1'b0;   // format select value
    localparam logic        FMT_BIN        = 1'b1;
endpackage : adc_link_pkg

// File: adc_link_if.sv
// adc_link_if: pins between the converter result port and the host reader
// assumes: open-collector flags are resolved here; tri-state data goes to the host unresolved, beside its enable
`timescale 1ns/1ps
interface adc_link_if;
    logic sclk;        // shift clock, host driven
    logic chain_in;    // upstream serial data into device
    logic sdata;       // device serial output value
    logic sdata_oe;    // device drives sdata
    logic xmit_en;     // transmit enable, host driven, active high
    logic ready;       // result ready
    logic ovr_pos_o;   // over-range high: pulls low when oe high
    logic ovr_pos_oe;
    logic ovr_neg_o;
    logic ovr_neg_oe;
    logic final_sample_start;
    logic ovr_pos_n;   // resolved wired-or level, active low
    logic ovr_neg_n;
    assign ovr_pos_n = ovr_pos_oe ? ovr_pos_o : 1'b1;
    assign ovr_neg_n = ovr_neg_oe ? ovr_neg_o : 1'b1;
    modport device (input sclk, chain_in, xmit_en, final_sample_start,
                    output sdata, sdata_oe, ready, ovr_pos_o, ovr_pos_oe, ovr_neg_o, ovr_neg_oe);
    modport host   (output sclk, xmit_en, final_sample_start,
                    input sdata, sdata_oe, ready, ovr_pos_n, ovr_neg_n);
endinterface : adc_link_if

// File: adc_result_reader.sv
// adc_result_reader: host end; starts conversions and reads chained words over apb
// assumes: apb master on clk_i; device samples the pins asynchronously
`timescale 1ns/1ps
module adc_result_reader
    import adc_link_pkg::*;
(
    input  wire logic        clk_i,      // system clock
    input  wire logic        resetn_i,   // async reset, active low
    adc_link_if.host         link,       // pins to device chain
    input  wire logic        psel,       // apb select
    input  wire logic        penable,    // apb enable
    input  wire logic        pwrite,     // apb direction
    input  wire logic [11:0] paddr,      // apb address
    input  wire logic [31:0] pwdata,     // apb write data
    output logic             pready,     // apb ready
    output logic [31:0]      prdata,     // apb read data
    output logic             pslverr     // apb error
);
    import adc_link_pkg::*;

    localparam logic [11:0] A_CTRL = 12'h000;  // [0] start, [8:1] bit count
    localparam logic [11:0] A_STAT = 12'h004;  // [0] busy [1] ready [2] ovr+ [3] ovr-
    localparam logic [11:0] A_DATA = 12'h008;  // last 32 shifted bits

    typedef enum logic [2:0] {
        H_IDLE = 3'b001,
        H_LOW  = 3'b010,
        H_HIGH = 3'b100
    } host_state_e;

    host_state_e      st_r;
    logic [CNT_W-1:0] bits_r, nbits_r;
    logic [7:0]       div_r;
    logic [31:0]      data_r;
    logic [2:0]       rdy_s, sd_s, op_s, on_s;
    logic             fss_r, ovp_r, ovn_r, rdy_d_r;
    logic [2:0]       fss_cnt_r;
    logic             acc, tick;

    assign acc     = psel && penable;
    assign pready  = 1'b1;
    assign pslverr = acc && !(paddr == A_CTRL || paddr == A_STAT || paddr == A_DATA);
    assign tick    = (div_r == 8'(SCLK_HALF_CYC - 1));  // see (R4)

    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            rdy_s <= 3'b000;
            sd_s  <= 3'b000;
            op_s  <= 3'b111;
            on_s  <= 3'b111;
        end
        else
        begin
            rdy_s <= {rdy_s[1:0], link.ready};
            sd_s  <= {sd_s[1:0], link.sdata};
            op_s  <= {op_s[1:0], link.ovr_pos_n};
            on_s  <= {on_s[1:0], link.ovr_neg_n};
        end
    end

    // capture flags on the rising ready, see (R14)
    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            rdy_d_r <= 1'b0;
            ovp_r   <= 1'b0;
            ovn_r   <= 1'b0;
        end
        else
        begin
            if (rdy_s[1] == rdy_s[2])
                rdy_d_r <= rdy_s[2];
            if ((rdy_s[1] == rdy_s[2]) && rdy_s[2] && !rdy_d_r)
            begin
                ovp_r <= !op_s[2];
                ovn_r <= !on_s[2];
            end
        end
    end

    // apb start, clock generation and shifting
    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            st_r    <= H_IDLE;
            bits_r  <= '0;
            nbits_r <= CNT_W'(RES_W);
            div_r   <= '0;
            data_r  <= '0;
            fss_r   <= 1'b0;
            fss_cnt_r <= 3'h0;
        end
        else
        begin
            // start stands several clocks so the device's three-stage filter sees it
            if (acc && pwrite && paddr == A_CTRL && pwdata[0])
            begin
                fss_r     <= 1'b1;  // see (R16)
                fss_cnt_r <= 3'(FSS_HOLD_CYC - 1);
            end
            else if (fss_cnt_r != 3'h0)
                fss_cnt_r <= fss_cnt_r - 3'h1;
            else
                fss_r <= 1'b0;
            if (acc && pwrite && paddr == A_CTRL)
                nbits_r <= pwdata[8:1];
            div_r <= (st_r == H_IDLE || tick) ? 8'h00 : div_r + 8'h01;
            case (st_r)
                H_IDLE:
                    if (rdy_d_r && nbits_r != '0)  // see (R3)
                    begin
                        st_r   <= H_LOW;  // transmit enabled, clock low
                        bits_r <= nbits_r;
                    end
                H_LOW:
                    if (tick)
                        st_r <= H_HIGH;
                H_HIGH:
                    if (tick)
                    begin
                        // synced data lags the pin by three clocks: this is the bit at the rise
                        data_r <= {data_r[30:0], sd_s[2]};
                        bits_r <= bits_r - 1'b1;
                        st_r   <= (bits_r == CNT_W'(1)) ? H_IDLE : H_LOW;  // see (R15)
                    end
                default:
                    st_r <= H_IDLE;
            endcase
        end
    end

    assign link.sclk               = (st_r == H_HIGH);  // see (R5)
    assign link.xmit_en            = (st_r != H_IDLE);
    assign link.final_sample_start = fss_r;

    always_comb
    begin
        prdata = 32'h0000_0000;
        if (acc && !pwrite)
        begin
            if (paddr == A_CTRL)
                prdata = {23'h00_0000, nbits_r, 1'b0};
            else if (paddr == A_STAT)
                prdata = {28'h000_0000, ovn_r, ovp_r, rdy_d_r, st_r != H_IDLE};
            else if (paddr == A_DATA)
                prdata = data_r;
        end
    end
endmodule : adc_result_reader

// File: adc_link_monitor.sv
// adc_link_monitor: concurrent checks on the pins between result port and host reader
// assumes: instanced beside adc_link_if in tb, all signals in the clk_i domain
`timescale 1ns/1ps
module adc_link_monitor
(
    input  wire logic clk_i,      // system clock
    input  wire logic resetn_i,   // async reset, active low
    input  wire logic sclk,       // shift clock
    input  wire logic sdata,      // serial output value
    input  wire logic sdata_oe,   // serial output enable
    input  wire logic xmit_en,    // transmit enable
    input  wire logic ready,      // result ready
    input  wire logic ovr_pos_o,  // over-range high pin value
    input  wire logic ovr_pos_oe, // over-range high pull-down enable
    input  wire logic ovr_neg_o,  // over-range low pin value
    input  wire logic ovr_neg_oe, // over-range low pull-down enable
    input  wire logic ovr_pos_n,  // resolved wired level
    input  wire logic ovr_neg_n   // resolved wired level
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!resetn_i);

    property p_oe_off;     (!xmit_en)[*5] |-> !sdata_oe; endproperty
    property p_pos_oc;     ovr_pos_oe |-> !ovr_pos_o && !ovr_pos_n; endproperty
    property p_neg_oc;     ovr_neg_oe |-> !ovr_neg_o && !ovr_neg_n; endproperty
    property p_res_idle;   !ovr_pos_oe && !ovr_neg_oe |-> ovr_pos_n && ovr_neg_n; endproperty
    property p_ready_hold; (!xmit_en)[*5] ##0 ready |=> ready; endproperty
    property p_ready_clr;  $rose(xmit_en) |-> ##[1:6] !ready; endproperty
    property p_ovr_clr;    $rose(ready) |-> ##[1:2] (!ovr_pos_oe && !ovr_neg_oe); endproperty
    // the device sees the shift clock through its pin filter: data moves four clocks after a fall
    property p_out_edge;
        $past(sdata_oe) && sdata_oe && $changed(sdata) |-> $past(sclk, 5) && !$past(sclk, 4);
    endproperty
    property p_sclk_gate;  !xmit_en |-> !sclk; endproperty

    a_oe_off:     assert property (p_oe_off)     else $error("output driven idle");
    a_pos_oc:     assert property (p_pos_oc)     else $error("high flag drives 1");
    a_neg_oc:     assert property (p_neg_oc)     else $error("low flag drives 1");
    a_res_idle:   assert property (p_res_idle)   else $error("flag not pulled up");
    a_ready_hold: assert property (p_ready_hold) else $error("ready dropped early");
    a_ready_clr:  assert property (p_ready_clr)  else $error("ready kept too long");
    a_ovr_clr:    assert property (p_ovr_clr)    else $error("flags not cleared");
    a_out_edge:   assert property (p_out_edge)   else $error("data off fall edge");
    a_sclk_gate:  assert property (p_sclk_gate)  else $error("clock outside frame");

    c_ready: cover property ($rose(ready));
    c_xmit:  cover property ($rose(xmit_en));
    c_pos:   cover property ($rose(ovr_pos_oe));
    c_neg:   cover property ($rose(ovr_neg_oe));
endmodule : adc_link_monitor

// File: tb.sv
// tb: both link ends joined, driven over apb and the converter-side inputs
// assumes: host reader starts conversions and shifts the chain without help
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin n_tests++; if ((gt) !== (ex)) begin \
    $display("unexpected %s exp %h got %h", nm, ex, gt); num_errors++; end end
module tb;
    import adc_link_pkg::*;
    logic             clk_i;
    logic             resetn_i;
    logic             psel;
    logic             penable;
    logic             pwrite;
    logic [11:0]      paddr;
    logic [31:0]      pwdata;
    logic             pready;
    logic [31:0]      prdata;
    logic             pslverr;
    logic             fmt_sel;
    logic [RES_W-1:0] conv_data;
    logic             dac_pos, dac_neg, flt_pos, flt_neg;
    logic             converting;
    int               num_errors;
    int               n_tests;
    logic [31:0]      rd;
    logic             err;

    adc_link_if lnk();
    adc_serial_result_port u_adc_serial_result_port (.clk_i(clk_i), .resetn_i(resetn_i),
        .link(lnk), .fmt_sel_i(fmt_sel), .conv_data_i(conv_data), .dac_ovr_pos_i(dac_pos),
        .dac_ovr_neg_i(dac_neg), .flt_ovr_pos_i(flt_pos), .flt_ovr_neg_i(flt_neg),
        .converting_o(converting));
    adc_result_reader u_adc_result_reader (.clk_i(clk_i), .resetn_i(resetn_i), .link(lnk),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pready(pready), .prdata(prdata), .pslverr(pslverr));
    adc_link_monitor u_adc_link_monitor (.clk_i(clk_i), .resetn_i(resetn_i),
        .sclk(lnk.sclk), .sdata(lnk.sdata), .sdata_oe(lnk.sdata_oe), .xmit_en(lnk.xmit_en),
        .ready(lnk.ready), .ovr_pos_o(lnk.ovr_pos_o), .ovr_pos_oe(lnk.ovr_pos_oe),
        .ovr_neg_o(lnk.ovr_neg_o), .ovr_neg_oe(lnk.ovr_neg_oe),
        .ovr_pos_n(lnk.ovr_pos_n), .ovr_neg_n(lnk.ovr_neg_n));

    initial
    begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end

    task give_verdict;
        $display("checks %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : give_verdict

    task apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        int i;
        @(posedge clk_i);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= wd;
        @(posedge clk_i);
        penable <= 1'b1;
        i = 0;
        do
        begin
            @(posedge clk_i);
            i++;
        end while (pready !== 1'b1 && i < 50);
        rd  = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1)
        begin
            num_errors++;
            give_verdict;
        end
    endtask : apb

    // waits bounded for ready (sel 0) or transmit enable (sel 1) to reach lvl
    task wait_pin(input int sel, input logic lvl, input int lim);
        int i;
        i = 0;
        while (((sel == 0) ? lnk.ready : lnk.xmit_en) !== lvl && i < lim)
        begin
            @(posedge clk_i);
            i++;
        end
        if (((sel == 0) ? lnk.ready : lnk.xmit_en) !== lvl)
        begin
            num_errors++;
            give_verdict;
        end
    endtask : wait_pin

    // one conversion: causes raised early, word read back from the host data register
    task run_conv(input logic fmt, input logic [20:0] word, input int nbits, input logic chn,
                  input logic [31:0] exp, input logic [31:0] mask);
        @(posedge clk_i);
        fmt_sel      <= fmt;
        conv_data    <= word;
        lnk.chain_in <= chn;
        apb(1'b1, 12'h000, (nbits << 1) | 1);
        @(posedge clk_i);
        dac_pos <= ~fmt;
        flt_neg <= fmt;
        repeat (10) @(posedge clk_i);
        dac_pos <= 1'b0;
        flt_neg <= 1'b0;
        repeat (4) @(posedge clk_i);
        `CHK("flag_pos", ~fmt, ~lnk.ovr_pos_n)
        `CHK("flag_neg", fmt, ~lnk.ovr_neg_n)
        `CHK("busy", 1'b1, converting)
        wait_pin(0, 1'b1, 300);
        `CHK("oe_idle", 1'b0, lnk.sdata_oe)
        repeat (3) @(posedge clk_i);
        `CHK("flags_clear", 2'b11, {lnk.ovr_pos_n, lnk.ovr_neg_n})
        wait_pin(1, 1'b1, 100);
        wait_pin(1, 1'b0, 1000);
        `CHK("ready_after", 1'b0, lnk.ready)
        repeat (4) @(posedge clk_i);
        apb(1'b0, 12'h008, 32'h0000_0000);
        `CHK("word", exp & mask, rd & mask)
        apb(1'b0, 12'h004, 32'h0000_0000);
        `CHK("stat_flags", {fmt, ~fmt}, rd[3:2])
        $display("test conversion fmt %0d bits %0d done", fmt, nbits);
    endtask : run_conv

    initial
    begin
        num_errors = 0;
        n_tests    = 0;
        resetn_i   = 1'b0;
        psel       = 1'b0;
        penable    = 1'b0;
        pwrite     = 1'b0;
        paddr      = 12'h000;
        pwdata     = 32'h0000_0000;
        fmt_sel    = FMT_TWOS;
        conv_data  = '0;
        dac_pos    = 1'b0;
        dac_neg    = 1'b0;
        flt_pos    = 1'b0;
        flt_neg    = 1'b0;
        lnk.chain_in = 1'b0;
        repeat (10) @(posedge clk_i);
        resetn_i <= 1'b1;
        @(posedge clk_i);
        `CHK("rst_ready", 1'b0, lnk.ready)
        `CHK("rst_flags", 2'b11, {lnk.ovr_pos_n, lnk.ovr_neg_n})
        apb(1'b0, 12'h000, 32'h0000_0000);
        `CHK("ctrl_count", 8'h15, rd[8:1])
        apb(1'b0, 12'h0FC, 32'h0000_0000);
        `CHK("unmapped_err", 1'b1, err)
        $display("test reset and map done");
        run_conv(FMT_TWOS, 21'h1A_5C3, 21, 1'b0, 32'h001A_5C3, 32'h001F_FFFF);
        run_conv(FMT_TWOS, 21'h0B_3A5, 26, 1'b1, {6'h0, 21'h0B_3A5, 5'h1F},
                 32'h03FF_FFFF);
        run_conv(FMT_BIN, 21'h0C_9A7, 21, 1'b0, {11'h0, 20'hC_9A7, 1'b0},
                 32'h001F_FFFF);
        @(posedge clk_i);
        dac_neg <= 1'b1;
        flt_pos <= 1'b1;
        apb(1'b1, 12'h000, (21 << 1) | 1);
        repeat (20) @(posedge clk_i);
        `CHK("flags_both", 2'b00, {lnk.ovr_pos_n, lnk.ovr_neg_n})
        dac_neg <= 1'b0;
        flt_pos <= 1'b0;
        wait_pin(1, 1'b0, 100);
        wait_pin(1, 1'b1, 300);
        wait_pin(1, 1'b0, 1000);
        apb(1'b0, 12'h004, 32'h0000_0000);
        `CHK("stat_both", 4'hC, rd[3:0])
        $display("test remaining causes done");
        give_verdict;
    end
endmodule : tb
